//--- rtl/sp1_pkg.sv
// package: register map, field layout, timing loads and state of serial port one
`default_nettype none
package sp1_pkg;
  // ==========================================
  // register indices (byte address = index * 4)
  localparam int          ADDR_W   = 12;
  localparam logic [7:0]  IDX_CTRL = 8'h98;
  localparam logic [7:0]  IDX_DATA = 8'h99;
  localparam logic [7:0]  IDX_OPT  = 8'hc0;
  localparam logic [7:0]  IDX_DIV  = 8'hc1;
  localparam logic [7:0]  IDX_IST  = 8'hc2;
  localparam logic [7:0]  IDX_IMSK = 8'hc3;
  // ==========================================
  // field positions
  localparam int CTRL_MODE_HI = 7;
  localparam int CTRL_MODE_LO = 6;
  localparam int CTRL_MP      = 5;
  localparam int CTRL_REN     = 4;
  localparam int CTRL_TX9     = 3;
  localparam int CTRL_RX9     = 2;
  localparam int CTRL_TXDONE  = 1;
  localparam int CTRL_RXDONE  = 0;
  localparam int OPT_ONE_WIRE = 0;
  localparam int OPT_FAST     = 1;
  localparam int EV_TX        = 0;
  localparam int EV_RX        = 1;
  // ==========================================
  // reset values and timing
  localparam logic [7:0] CTRL_RST     = 8'h00;
  localparam logic [7:0] DIV_RST      = 8'h0f;
  localparam logic [7:0] LOAD_M2_SLOW = 8'h03;
  localparam logic [7:0] LOAD_M2_FAST = 8'h01;
  localparam logic [3:0] SMP_MID      = 4'h7;
  localparam logic [3:0] SMP_LAST     = 4'hf;
  localparam logic [3:0] BITS_ASYNC8  = 4'ha;
  localparam logic [3:0] BITS_ASYNC9  = 4'hb;
  localparam logic [3:0] BITS_SHIFT   = 4'h8;

  typedef enum logic [1:0] {
    SP1_M_SHIFT  = 2'b00,
    SP1_M_ASYNC8 = 2'b01,
    SP1_M_FIX9   = 2'b10,
    SP1_M_VAR9   = 2'b11
  } sp1_mode_t;

  typedef struct packed {
    logic [7:0]  ctrl;
    logic [1:0]  opt;
    logic [7:0]  div;
    logic [1:0]  ist;
    logic [1:0]  imsk;
    logic [7:0]  rxbuf;
    logic [10:0] txsh;
    logic        tx_busy;
    logic [3:0]  tx_cnt;
    logic [3:0]  tx_ph;
    logic [8:0]  rxsh;
    logic        rx_busy;
    logic [3:0]  rx_cnt;
    logic [3:0]  rx_ph;
    logic        m0_ph;
    logic [7:0]  pres;
    logic        s_rx1;
    logic        s_rx2;
    logic        s_tx1;
    logic        s_tx2;
    logic        rx_prev;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        txd_o;
    logic        txd_oe_n;
    logic        rxd_o;
    logic        rxd_oe_n;
  } sp1_state_t;

  localparam sp1_state_t SP1_RST = '{
    ctrl: CTRL_RST, div: DIV_RST, txsh: 11'h7ff,
    s_rx1: 1'b1, s_rx2: 1'b1, s_tx1: 1'b1, s_tx2: 1'b1, rx_prev: 1'b1,
    txd_o: 1'b1, rxd_o: 1'b1, rxd_oe_n: 1'b1, default: '0};
endpackage
`default_nettype wire

//--- rtl/sp1_serial_port.sv
// serial port one: shift-register and asynchronous modes behind an apb slave
`default_nettype none
module sp1_serial_port (
  input  wire logic                      sys_clk,
  input  wire logic                      srst,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [sp1_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  output logic                           irq,
  input  wire logic                      txd_i,
  output logic                           txd_o,
  output logic                           txd_oe_n,
  input  wire logic                      rxd_i,
  output logic                           rxd_o,
  output logic                           rxd_oe_n
);
  sp1_pkg::sp1_state_t q;
  sp1_pkg::sp1_state_t n;
  sp1_pkg::sp1_mode_t  mode;
  sp1_pkg::sp1_mode_t  nmode;
  logic                setup;
  logic                wr;
  logic                hit;
  logic [7:0]          idx;
  logic [7:0]          rd;
  logic                line;
  logic                tick;
  logic                nine;
  logic                keep;
  logic                tx_ev;
  logic                rx_ev;

  // ==========================================
  // helpers
  // sample-tick reload per mode
  function automatic logic [7:0] tick_load(input sp1_pkg::sp1_mode_t m,
                                           input logic fast,
                                           input logic [7:0] dv);
    logic [7:0] r;
    r = dv;
    unique case (m)
      sp1_pkg::SP1_M_FIX9: r = fast ? sp1_pkg::LOAD_M2_FAST : sp1_pkg::LOAD_M2_SLOW;
      sp1_pkg::SP1_M_SHIFT,
      sp1_pkg::SP1_M_ASYNC8,
      sp1_pkg::SP1_M_VAR9: r = dv;
    endcase
    return r;
  endfunction

  function automatic logic is_nine(input sp1_pkg::sp1_mode_t m);
    return m == sp1_pkg::SP1_M_FIX9 || m == sp1_pkg::SP1_M_VAR9;
  endfunction

  // ==========================================
  // next state
  always_comb begin
    n     = q;
    mode  = sp1_pkg::sp1_mode_t'(q.ctrl[sp1_pkg::CTRL_MODE_HI:sp1_pkg::CTRL_MODE_LO]);
    nine  = is_nine(mode);
    setup = psel & ~penable;
    wr    = psel & penable & q.pready & pwrite;
    idx   = paddr[9:2];
    hit   = (paddr[sp1_pkg::ADDR_W-1:10] == '0) && (paddr[1:0] == 2'b00);
    tx_ev = 1'b0;
    rx_ev = 1'b0;
    keep  = 1'b0;

    // pin synchronisers
    n.s_rx1 = rxd_i;
    n.s_rx2 = q.s_rx1;
    n.s_tx1 = txd_i;
    n.s_tx2 = q.s_tx1;
    line      = q.opt[sp1_pkg::OPT_ONE_WIRE] ? q.s_tx2 : q.s_rx2;
    n.rx_prev = line;

    tick   = (q.pres == 8'h00);
    n.pres = tick ? tick_load(mode, q.opt[sp1_pkg::OPT_FAST], q.div) : q.pres - 8'h01;

    if (mode == sp1_pkg::SP1_M_SHIFT && (q.tx_busy || q.rx_busy)) begin
      n.m0_ph = ~q.m0_ph;
    end else begin
      n.m0_ph = 1'b0;
    end

    // ==========================================
    // apb slave
    rd = 8'h00;
    unique case (idx)
      sp1_pkg::IDX_CTRL: rd = q.ctrl;
      sp1_pkg::IDX_DATA: rd = q.rxbuf;
      sp1_pkg::IDX_OPT:  rd = {6'h00, q.opt};
      sp1_pkg::IDX_DIV:  rd = q.div;
      sp1_pkg::IDX_IST:  rd = {6'h00, q.ist};
      sp1_pkg::IDX_IMSK: rd = {6'h00, q.imsk};
      default:           rd = 8'h00;
    endcase
    n.pready  = setup;
    n.pslverr = setup & ~(hit && (idx == sp1_pkg::IDX_CTRL || idx == sp1_pkg::IDX_DATA ||
                                  idx == sp1_pkg::IDX_OPT || idx == sp1_pkg::IDX_DIV ||
                                  idx == sp1_pkg::IDX_IST || idx == sp1_pkg::IDX_IMSK));
    n.prdata  = (setup && !pwrite && hit) ? {24'h000000, rd} : 32'h00000000;

    if (wr && hit) begin
      unique case (idx)
        sp1_pkg::IDX_CTRL: n.ctrl = pwdata[7:0];
        sp1_pkg::IDX_DATA: begin
          if (!q.tx_busy && !(mode == sp1_pkg::SP1_M_SHIFT && q.rx_busy)) begin
            n.tx_busy = 1'b1;
            n.tx_ph   = 4'h0;
            if (mode == sp1_pkg::SP1_M_SHIFT) begin
              n.txsh   = {3'b111, pwdata[7:0]};
              n.tx_cnt = sp1_pkg::BITS_SHIFT;
            end else begin
              n.txsh   = {1'b1, nine ? q.ctrl[sp1_pkg::CTRL_TX9] : 1'b1, pwdata[7:0], 1'b0};
              n.tx_cnt = nine ? sp1_pkg::BITS_ASYNC9 : sp1_pkg::BITS_ASYNC8;
            end
          end
        end
        sp1_pkg::IDX_OPT:  n.opt  = pwdata[1:0];
        sp1_pkg::IDX_DIV:  n.div  = pwdata[7:0];
        sp1_pkg::IDX_IST:  n.ist  = q.ist & ~pwdata[1:0];
        sp1_pkg::IDX_IMSK: n.imsk = pwdata[1:0];
        default: ;
      endcase
    end

    // ==========================================
    // transmitter
    if (q.tx_busy) begin
      if (mode == sp1_pkg::SP1_M_SHIFT) begin
        if (q.m0_ph) begin
          // shift lsb first at clock fall
          n.txsh   = {1'b1, q.txsh[10:1]};
          n.tx_cnt = q.tx_cnt - 4'h1;
          if (q.tx_cnt == 4'h1) begin
            // done at end of eighth bit
            tx_ev     = 1'b1;
            n.tx_busy = 1'b0;
          end
        end
      end else if (tick) begin
        n.tx_ph = q.tx_ph + 4'h1;
        if (q.tx_ph == sp1_pkg::SMP_LAST) begin
          n.txsh   = {1'b1, q.txsh[10:1]};
          n.tx_cnt = q.tx_cnt - 4'h1;
          if (q.tx_cnt == 4'h2) begin
            tx_ev = 1'b1;
          end
          if (q.tx_cnt == 4'h1) begin
            n.tx_busy = 1'b0;
          end
        end
      end
    end

    // ==========================================
    // receiver
    if (!q.ctrl[sp1_pkg::CTRL_REN]) begin
      n.rx_busy = 1'b0;
    end else if (q.rx_busy) begin
      if (mode == sp1_pkg::SP1_M_SHIFT) begin
        if (q.m0_ph) begin
          n.rxsh   = {q.s_rx2, q.rxsh[8:1]};
          n.rx_cnt = q.rx_cnt + 4'h1;
          if (q.rx_cnt == sp1_pkg::BITS_SHIFT - 4'h1) begin
            // done at end of eighth bit
            n.rxbuf   = {q.s_rx2, q.rxsh[8:2]};
            rx_ev     = 1'b1;
            n.rx_busy = 1'b0;
          end
        end
      end else if (tick) begin
        n.rx_ph = q.rx_ph + 4'h1;
        if (q.rx_ph == sp1_pkg::SMP_MID) begin
          if (q.rx_cnt == 4'h0 && line) begin
            n.rx_busy = 1'b0;
          end else if (q.rx_cnt == (nine ? sp1_pkg::BITS_ASYNC9 : sp1_pkg::BITS_ASYNC8)
                                   - 4'h1) begin
            keep      = !q.ctrl[sp1_pkg::CTRL_MP] || (nine ? q.rxsh[8] : line);
            n.rx_busy = 1'b0;
            if (keep) begin
              n.rxbuf                    = nine ? q.rxsh[7:0] : q.rxsh[8:1];
              n.ctrl[sp1_pkg::CTRL_RX9]  = nine ? q.rxsh[8] : line;
              rx_ev                      = 1'b1;
            end
          end else begin
            if (q.rx_cnt != 4'h0) begin
              n.rxsh = {line, q.rxsh[8:1]};
            end
            n.rx_cnt = q.rx_cnt + 4'h1;
          end
        end
      end
    end else if (mode == sp1_pkg::SP1_M_SHIFT) begin
      // shift receive waits for a cleared done flag
      if (!q.ctrl[sp1_pkg::CTRL_RXDONE] && !n.tx_busy) begin
        n.rx_busy = 1'b1;
        n.rx_cnt  = 4'h0;
      end
    end else if (q.rx_prev && !line) begin
      n.rx_busy = 1'b1;
      n.rx_cnt  = 4'h0;
      n.rx_ph   = 4'h0;
    end

    // hardware only sets, set wins over clear
    if (tx_ev) begin
      n.ctrl[sp1_pkg::CTRL_TXDONE] = 1'b1;
      n.ist[sp1_pkg::EV_TX]        = 1'b1;
    end
    if (rx_ev) begin
      n.ctrl[sp1_pkg::CTRL_RXDONE] = 1'b1;
      n.ist[sp1_pkg::EV_RX]        = 1'b1;
    end
    n.irq = |(n.ist & n.imsk);

    // ==========================================
    // pin drive
    nmode = sp1_pkg::sp1_mode_t'(n.ctrl[sp1_pkg::CTRL_MODE_HI:sp1_pkg::CTRL_MODE_LO]);
    if (nmode == sp1_pkg::SP1_M_SHIFT) begin
      // shift clock out, data both ways
      n.txd_o    = (n.tx_busy || n.rx_busy) ? n.m0_ph : 1'b1;
      n.txd_oe_n = 1'b0;
      n.rxd_o    = n.tx_busy ? n.txsh[0] : 1'b1;
      n.rxd_oe_n = ~n.tx_busy;
    end else begin
      n.txd_o    = n.tx_busy ? n.txsh[0] : 1'b1;
      n.txd_oe_n = n.opt[sp1_pkg::OPT_ONE_WIRE] & ~n.tx_busy;
      n.rxd_o    = 1'b1;
      n.rxd_oe_n = 1'b1;
    end
  end

  // ==========================================
  // state register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      q <= sp1_pkg::SP1_RST;
    end else begin
      q <= n;
    end
  end

  assign prdata   = q.prdata;
  assign pready   = q.pready;
  assign pslverr  = q.pslverr;
  assign irq      = q.irq;
  assign txd_o    = q.txd_o;
  assign txd_oe_n = q.txd_oe_n;
  assign rxd_o    = q.rxd_o;
  assign rxd_oe_n = q.rxd_oe_n;
endmodule
`default_nettype wire

//--- tb/sp1_checker.sv
// checker: bus and pin timing relations of serial port one
`default_nettype none
module sp1_checker (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire logic        txd_o,
  input wire logic        txd_oe_n,
  input wire logic        rxd_o,
  input wire logic        rxd_oe_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ==========================================
  // bus and pin relations
  a_reset_idle: assert property (disable iff (1'b0)
    srst |=> !pready && !pslverr && !irq && txd_o && !txd_oe_n && rxd_o && rxd_oe_n)
    else $error("outputs not idle after reset");
  a_ready_pulse: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held two cycles");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_read_idle: assert property (prdata[31:8] == '0 && (pready || prdata == '0))
    else $error("read data outside access");
  a_drive_pair: assert property (!rxd_oe_n |-> !txd_oe_n)
    else $error("shift data driven without clock");
  a_shift_toggle: assert property (!rxd_oe_n && $past(!rxd_oe_n) |-> txd_o != $past(txd_o))
    else $error("shift clock not toggling");
  a_data_hold: assert property (!rxd_oe_n && txd_o && $past(!rxd_oe_n) |-> $stable(rxd_o))
    else $error("shift data changed at clock high");
  c_shift: cover property (!rxd_oe_n);
  c_err: cover property (pslverr);
  c_irq: cover property (irq);
endmodule
`default_nettype wire

//--- tb/sp1_node.sv
// partner: remote serial node on the line
`default_nettype none
module sp1_node (
  input  wire logic       clk,
  input  wire logic       txd,
  output logic            rxd,
  output logic            got,
  output logic [8:0]      word
);
  timeunit 1ns;
  timeprecision 1ps;
  int   per = 16;
  int   nb  = 8;
  logic on  = 1'b0;
  initial begin
    rxd = 1'b1;
    got = 1'b0;
    word = '0;
  end
  // start low, lsb first, stop level
  task automatic send(input logic [8:0] d, input int n, input logic stp);
    for (int i = 0; i < n + 2; i++) begin
      rxd <= (i == 0) ? 1'b0 : (i > n) ? stp : d[i-1];
      repeat (per) @(posedge clk);
    end
    rxd <= 1'b1;
  endtask
  // mid-bit sampling, stop must be high
  always begin
    @(posedge clk);
    got <= 1'b0;
    if (on && !txd) begin
      repeat (per / 2) @(posedge clk);
      for (int i = 0; i <= nb; i++) begin
        repeat (per) @(posedge clk);
        if (i < nb) word[i] <= txd;
      end
      got <= txd;
    end
  end
endmodule
`default_nettype wire

//--- tb/serial_port_one_test.sv
// testbench: serial port one against a remote node model
`default_nettype none
module serial_port_one_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // signals
  logic        sys_clk = 1'b0;
  logic        srst    = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, irq, txd_o, txd_oe_n, rxd_o, rxd_oe_n, nrx, got;
  logic [8:0]  word, b;
  logic        ow     = 1'b0;
  logic [7:0]  sh_cap = 8'h00;
  logic [8:0]  fq[$];
  logic [31:0] rq[$];
  logic [19:0] rx_tab [5] = '{20'hf0f06, 20'hf0f57, 20'h40402, 20'h70700, 20'h50552};
  int          n_mismatch = 0;
  int          cmp_count  = 0;
  int          cyc        = 0;
  int          seed       = 32'h4257;
  // released txd carries the node's line (one-wire); ow holds rxd high
  wire logic   txd_w = txd_oe_n ? nrx : txd_o;
  wire logic   rxd_w = rxd_oe_n ? (nrx | ow) : rxd_o;

  always #2 sys_clk = ~sys_clk;

  sp1_serial_port i_sp1_serial_port (
    .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .txd_i(txd_w), .txd_o(txd_o), .txd_oe_n(txd_oe_n), .rxd_i(rxd_w),
    .rxd_o(rxd_o), .rxd_oe_n(rxd_oe_n));
  sp1_node i_sp1_node (.clk(sys_clk), .txd(txd_w), .rxd(nrx), .got(got), .word(word));
  // ==========================================
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, {24'h0, d});
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    rq.push_back(e);
    apb(1'b0, idx, 32'h0);
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge sys_clk);
    check({31'h0, irq}, {31'h0, e}, "irq");
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0 && fq.size() == 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================
  // result watcher
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    // shift data taken while shift clock high
    if (!rxd_oe_n && txd_o === 1'b1)
      sh_cap <= {rxd_o, sh_cap[7:1]};
    if (psel && penable && pready === 1'b1 && !pwrite)
      check({pslverr, prdata[30:0]}, rq.pop_front(), "read");
    if (got === 1'b1)
      check({23'h0, word}, {23'h0, fq.pop_front()}, "frame");
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // ==========================================
  // main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    rd(sp1_pkg::IDX_CTRL, 32'h0);
    rd(sp1_pkg::IDX_DIV, 32'hf);
    rd(8'h10, 32'h8000_0000);
    wr(sp1_pkg::IDX_DIV, 8'h00);
    wr(sp1_pkg::IDX_OPT, 8'h02);
    wr(sp1_pkg::IDX_IMSK, 8'h03);
    $display("test registers ended");
    i_sp1_node.on = 1'b1;
    for (int m = 1; m < 4; m++) begin
      b = 9'($random(seed));
      i_sp1_node.per = (m == 2) ? 32 : 16;
      i_sp1_node.nb = (m == 1) ? 8 : 9;
      wr(sp1_pkg::IDX_CTRL, {m[1:0], 2'b00, b[8], 3'b000});
      fq.push_back((m == 1) ? {1'b0, b[7:0]} : b);
      wr(sp1_pkg::IDX_DATA, b[7:0]);
      while (fq.size() != 0) @(posedge sys_clk);
      rd(sp1_pkg::IDX_CTRL, {24'h0, m[1:0], 2'b00, b[8], 3'b010});
      irq_is(1'b1);
      wr(sp1_pkg::IDX_IMSK, 8'h00);
      irq_is(1'b0);
      wr(sp1_pkg::IDX_IMSK, 8'h03);
      wr(sp1_pkg::IDX_IST, 8'h03);
      irq_is(1'b0);
      repeat (32) @(posedge sys_clk);
    end
    $display("test transmit ended");
    i_sp1_node.on = 1'b0;
    wr(sp1_pkg::IDX_CTRL, 8'h00);
    wr(sp1_pkg::IDX_DATA, b[7:0]);
    repeat (24) @(posedge sys_clk);
    check({24'h0, sh_cap}, {24'h0, b[7:0]}, "shift data");
    rd(sp1_pkg::IDX_CTRL, 32'h2);
    $display("test shift ended");
    i_sp1_node.per = 16;
    foreach (rx_tab[k]) begin
      b = {rx_tab[k][0], 8'($random(seed))};
      wr(sp1_pkg::IDX_CTRL, rx_tab[k][19:12]);
      i_sp1_node.send(b, rx_tab[k][2] ? 9 : 8, rx_tab[k][1]);
      repeat (4) @(posedge sys_clk);
      rd(sp1_pkg::IDX_CTRL, {24'h0, rx_tab[k][11:4]});
      if (rx_tab[k][4]) rd(sp1_pkg::IDX_DATA, {24'h0, b[7:0]});
    end
    $display("test receive ended");
    ow <= 1'b1;
    wr(sp1_pkg::IDX_OPT, 8'h03);
    wr(sp1_pkg::IDX_CTRL, 8'h50);
    b = {1'b1, 8'($random(seed))};
    i_sp1_node.send(b, 8, 1'b1);
    repeat (4) @(posedge sys_clk);
    rd(sp1_pkg::IDX_CTRL, 32'h55);
    rd(sp1_pkg::IDX_DATA, {24'h0, b[7:0]});
    $display("test one wire ended");
    print_verdict();
  end
endmodule

bind sp1_serial_port sp1_checker i_sp1_checker (.sys_clk(sys_clk), .srst(srst), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
  .txd_o(txd_o), .txd_oe_n(txd_oe_n), .rxd_o(rxd_o), .rxd_oe_n(rxd_oe_n));
`default_nettype wire
